// File: fcr_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_config
(
	// System clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial link, clocked by the host
	input  wire logic        linkClk,
	input  wire logic        chipSelN,
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             serialOutEnN,
	// Read address wrapping
	input  wire logic [23:0] readAddr,
	output logic      [23:0] nextAddr,
	// Active configuration
	output logic      [3:0]  dummyCycles,
	output logic      [2:0]  xipBootMode,
	output logic             executeInPlace,
	output logic      [2:0]  driveStrength,
	output logic             doubleRate,
	output logic             dataLineThreePause,
	output logic             quadProtocol,
	output logic             dualProtocol,
	output fcr_pkg::fcr_wrap_t wrapMode,
	// Status
	output logic             writeInProgress,
	output logic             writeEnableLatch
);
	// ---------------------------------------------------------------
	// Link domain: command shifter
	// ---------------------------------------------------------------
	logic [7:0]  shift_q;
	logic [2:0]  bitCnt_q;
	fcr_pkg::fcr_state_t state_q;
	logic [7:0]  cmd_q;
	logic [15:0] wdata_q;
	logic        wrTog_q;
	logic [1:0]  wrKind_q;
	logic        wrenTog_q;
	logic [15:0] rdShift_q;
	logic [7:0]  nextByte;

	assign nextByte = {shift_q[6:0], serialIn};

	// Shifter runs only while the host clocks a frame; chip select
	// restarts it so a clipped frame leaves no residue.
	always_ff @(posedge linkClk or posedge chipSelN)
	begin
		if (chipSelN)
		begin
			shift_q  <= 8'h00;
			bitCnt_q <= 3'h0;
			state_q  <= fcr_pkg::FCR_CMD;
			cmd_q    <= 8'h00;
			wdata_q  <= 16'h0000;
		end
		else
		begin
			shift_q  <= nextByte;
			bitCnt_q <= bitCnt_q + 3'h1;
			if (bitCnt_q == 3'h7)
			begin
				case (state_q)
					fcr_pkg::FCR_CMD:
					begin
						cmd_q   <= nextByte;
						state_q <= fcr_pkg::FCR_HI;
					end
					fcr_pkg::FCR_HI:
					begin
						wdata_q[15:8] <= nextByte;
						state_q       <= fcr_pkg::FCR_LO;
					end
					fcr_pkg::FCR_LO:
					begin
						wdata_q[7:0] <= nextByte;
						state_q      <= fcr_pkg::FCR_END;
					end
					fcr_pkg::FCR_END: state_q <= fcr_pkg::FCR_END;
					default:          state_q <= fcr_pkg::FCR_CMD;
				endcase
			end
		end
	end

	// Write events toggle across to the system domain; they are not reset
	// by chip select so a completed write is never withdrawn.
	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			wrTog_q   <= 1'b0;
			wrKind_q  <= 2'h0;
			wrenTog_q <= 1'b0;
		end
		else if (!chipSelN && bitCnt_q == 3'h7)
		begin
			if (state_q == fcr_pkg::FCR_CMD && nextByte == `FCR_CMD_WREN)
				wrenTog_q <= ~wrenTog_q;
			else if (state_q == fcr_pkg::FCR_HI && cmd_q == `FCR_CMD_WR_RC)
			begin
				wrKind_q <= 2'h1;
				wrTog_q  <= ~wrTog_q;
			end
			else if (state_q == fcr_pkg::FCR_LO && cmd_q == `FCR_CMD_WR_PC)
			begin
				wrKind_q <= 2'h2;
				wrTog_q  <= ~wrTog_q;
			end
		end
	end

	// Runtime write carries its byte in the high data slot.
	logic [15:0] wrWord;
	assign wrWord = (state_q == fcr_pkg::FCR_HI) ? {nextByte, 8'h00}
		: {wdata_q[15:8], nextByte};
	logic [15:0] xferData_q;

	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
			xferData_q <= 16'h0000;
		else if (!chipSelN && bitCnt_q == 3'h7 &&
			state_q != fcr_pkg::FCR_CMD)
			xferData_q <= wrWord;
	end

	// Read data is shifted out on the falling edge, most significant
	// first. Register values are sampled without a full crossing; they
	// are stable for the whole frame unless written within it.
	logic [15:0] pcRead;
	logic [7:0]  rcRead;
	logic [15:0] pc_q;
	logic [7:0]  rc_q;

	always_ff @(negedge linkClk or posedge chipSelN)
	begin
		if (chipSelN)
		begin
			rdShift_q    <= 16'h0000;
			serialOutEnN <= 1'b1;
			serialOut    <= 1'b0;
		end
		else if (state_q == fcr_pkg::FCR_HI && bitCnt_q == 3'h0 &&
			(cmd_q == `FCR_CMD_RD_PC || cmd_q == `FCR_CMD_RD_RC))
		begin
			rdShift_q    <= (cmd_q == `FCR_CMD_RD_PC) ? {pcRead[14:0], 1'b0}
				: {rcRead[6:0], 9'h000};
			serialOut    <= (cmd_q == `FCR_CMD_RD_PC) ? pcRead[15] : rcRead[7];
			serialOutEnN <= 1'b0;
		end
		else
		begin
			rdShift_q <= {rdShift_q[14:0], 1'b0};
			serialOut <= rdShift_q[15];
		end
	end

	// ---------------------------------------------------------------
	// System domain: crossing and registers
	// ---------------------------------------------------------------
	logic wrTogS;
	logic wrenTogS;
	logic wrTogSeen_q;
	logic wrenTogSeen_q;

	fcr_sync uSyncWr
	(
		.clk (clk),
		.rst (rst),
		.d   (wrTog_q),
		.q   (wrTogS)
	);

	fcr_sync uSyncWren
	(
		.clk (clk),
		.rst (rst),
		.d   (wrenTog_q),
		.q   (wrenTogS)
	);

	logic wrEvent;
	logic wrenEvent;
	assign wrEvent   = wrTogS ^ wrTogSeen_q;
	assign wrenEvent = wrenTogS ^ wrenTogSeen_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrTogSeen_q   <= 1'b0;
			wrenTogSeen_q <= 1'b0;
		end
		else
		begin
			wrTogSeen_q   <= wrTogS;
			wrenTogSeen_q <= wrenTogS;
		end
	end

	// Data word is written on the same link edge that moves the toggle.
	logic acceptWrite;
	assign acceptWrite = wrEvent && writeEnableLatch && !writeInProgress;

	// Persistent contents and their valid flag survive reset, so a
	// written image is what the next reset copies in; the flag starts
	// clear to stand for the erased state at power-on.
	logic pcValid_q = 1'b0;
	always_ff @(posedge clk)
	begin
		if (acceptWrite && wrKind_q == 2'h2)
		begin
			pc_q      <= xferData_q | `FCR_PC_RSVD_MASK;
			pcValid_q <= 1'b1;
		end
	end

	assign pcRead = pcValid_q ? pc_q : `FCR_PC_RESET;
	assign rcRead = rc_q;

	// Write enable latch: set by its command, cleared by any write.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			writeEnableLatch <= 1'b0;
		else if (wrenEvent)
			writeEnableLatch <= 1'b1;
		else if (wrEvent)
			writeEnableLatch <= 1'b0;
	end

	logic [15:0] busyCnt_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busyCnt_q <= 16'h0000;
		else if (acceptWrite && wrKind_q == 2'h2)
			busyCnt_q <= 16'(`FCR_PC_WRITE_CYC);
		else if (busyCnt_q != 16'h0000)
			busyCnt_q <= busyCnt_q - 16'h0001;
	end
	assign writeInProgress = busyCnt_q != 16'h0000;

	// Hidden register: loaded from the persistent image after reset only; the
	// runtime register with it, then by each accepted runtime write. Persistent
	// writes take effect only at the next reset.
	logic loadPending_q;
	logic [15:0] icPc_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			loadPending_q <= 1'b1;
			icPc_q        <= `FCR_PC_RESET;
			rc_q          <= `FCR_RC_RESET;
		end
		else if (loadPending_q)
		begin
			loadPending_q <= 1'b0;
			icPc_q        <= pcRead;
			rc_q          <= {pcRead[`FCR_PC_DUMMY_HI:`FCR_PC_DUMMY_LO], 1'b1,
				1'b0, 2'h3};
		end
		else if (acceptWrite && wrKind_q == 2'h1)
			rc_q <= xferData_q[15:8] & ~`FCR_RC_RSVD_MASK;
	end

	// ---------------------------------------------------------------
	// Decoded active configuration
	// ---------------------------------------------------------------
	logic [3:0] dummyRaw;
	assign dummyRaw    = rc_q[`FCR_RC_DUMMY_HI:`FCR_RC_DUMMY_LO];
	assign dummyCycles = (dummyRaw == 4'h0) ? 4'hf : dummyRaw;
	assign xipBootMode = icPc_q[`FCR_PC_XIP_HI:`FCR_PC_XIP_LO];
	assign executeInPlace = !rc_q[`FCR_RC_XIP_BIT] ||
		(xipBootMode <= 3'h4);
	assign driveStrength = icPc_q[`FCR_PC_DRV_HI:`FCR_PC_DRV_LO];
	assign doubleRate    = !icPc_q[`FCR_PC_DTR_BIT];
	assign dataLineThreePause = icPc_q[`FCR_PC_PAUSE_BIT];
	assign quadProtocol  = !icPc_q[`FCR_PC_QUAD_BIT];
	assign dualProtocol  = !icPc_q[`FCR_PC_DUAL_BIT] &&
		icPc_q[`FCR_PC_QUAD_BIT];
	assign wrapMode = fcr_pkg::fcr_wrap_t'(rc_q[`FCR_RC_WRAP_HI:`FCR_RC_WRAP_LO]);

	// Next read address: wraps inside the aligned block, except in continuous mode, where it just increments.
	always_comb
	begin
		nextAddr = readAddr + 24'h000001;
		case (wrapMode)
			fcr_pkg::FCR_WRAP16: nextAddr[3:0] = readAddr[3:0] + 4'h1;
			fcr_pkg::FCR_WRAP32: nextAddr[4:0] = readAddr[4:0] + 5'h01;
			fcr_pkg::FCR_WRAP64: nextAddr[5:0] = readAddr[5:0] + 6'h01;
			default:             nextAddr = readAddr + 24'h000001;
		endcase
		if (wrapMode != fcr_pkg::FCR_CONT)
			nextAddr[23:6] = readAddr[23:6];
		if (wrapMode == fcr_pkg::FCR_WRAP16)
			nextAddr[5:4] = readAddr[5:4];
		if (wrapMode == fcr_pkg::FCR_WRAP32)
			nextAddr[5] = readAddr[5];
	end
endmodule : fcr_config
`default_nettype wire

// File: fcr_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.svh"
module fcr_config_chk
(
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst,
	// Observed ports
	input wire logic               chipSelN,
	input wire logic               serialOutEnN,
	input wire logic [23:0]        readAddr,
	input wire logic [23:0]        nextAddr,
	input wire logic [3:0]         dummyCycles,
	input wire logic               quadProtocol,
	input wire logic               dualProtocol,
	input wire fcr_pkg::fcr_wrap_t wrapMode,
	input wire logic               writeInProgress,
	input wire logic               writeEnableLatch
);
	logic [23:0] blkMask;
	logic [8:0]  busyCnt_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	assign blkMask = (wrapMode == fcr_pkg::FCR_CONT) ? 24'hffffff :
		(24'h000010 << wrapMode) - 24'h000001;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			busyCnt_q <= 9'h000;
		else
			busyCnt_q <= writeInProgress ? busyCnt_q + 9'h001 : 9'h000;

	chk_dummy_nonzero: assert property (dummyCycles != 4'h0)
		else $error("dummy count zero");
	chk_quad_wins: assert property (!(quadProtocol && dualProtocol))
		else $error("dual and quad both on");
	chk_busy_length: assert property ($fell(writeInProgress) |->
		busyCnt_q == `FCR_PC_WRITE_CYC) else $error("busy length wrong");
	chk_latch_clears: assert property ($rose(writeInProgress) |->
		##[0:4] !writeEnableLatch) else $error("latch kept");
	chk_out_released: assert property (chipSelN [*3] |-> serialOutEnN)
		else $error("output driven outside frame");
	chk_wrap_next: assert property (nextAddr ==
		((readAddr & ~blkMask) | ((readAddr + 24'h000001) & blkMask)))
		else $error("wrapped address wrong");
	chk_wrap_cont: assert property (wrapMode == fcr_pkg::FCR_CONT |->
		nextAddr == readAddr + 24'h000001) else $error("continuous wrong");
	chk_reset_load: assert property ($fell(rst) |-> ##3
		(wrapMode == fcr_pkg::FCR_CONT) [*4]) else $error("reset load wrong");

	cover property ($rose(writeInProgress));
	cover property (wrapMode == fcr_pkg::FCR_WRAP16);
	cover property (quadProtocol);
endmodule : fcr_config_chk

bind fcr_config fcr_config_chk fcr_config_chk_inst (.clk, .rst, .chipSelN,
	.serialOutEnN, .readAddr, .nextAddr, .dummyCycles, .quadProtocol,
	.dualProtocol, .wrapMode, .writeInProgress, .writeEnableLatch);
`default_nettype wire

// File: fcr_defines.svh
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH

// Persistent register fields and reset image (erased state).
`define FCR_PC_RESET       16'hffff
`define FCR_PC_DUMMY_HI    15
`define FCR_PC_DUMMY_LO    12
`define FCR_PC_XIP_HI      11
`define FCR_PC_XIP_LO      9
`define FCR_PC_DRV_HI      8
`define FCR_PC_DRV_LO      6
`define FCR_PC_DTR_BIT     5
`define FCR_PC_PAUSE_BIT   4
`define FCR_PC_QUAD_BIT    3
`define FCR_PC_DUAL_BIT    2
`define FCR_PC_RSVD_MASK   16'h0003

// Runtime register fields and reset value.
`define FCR_RC_RESET       8'hfb
`define FCR_RC_DUMMY_HI    7
`define FCR_RC_DUMMY_LO    4
`define FCR_RC_XIP_BIT     3
`define FCR_RC_RSVD_MASK   8'h04
`define FCR_RC_WRAP_HI     1
`define FCR_RC_WRAP_LO     0

// Command codes (arbitrary choice of this block).
`define FCR_CMD_WREN       8'h06
`define FCR_CMD_RD_PC      8'hb5
`define FCR_CMD_WR_PC      8'hb1
`define FCR_CMD_RD_RC      8'h85
`define FCR_CMD_WR_RC      8'h81

// Nonvolatile write cycle length.
`define FCR_PC_WRITE_NS    1000
`define FCR_CLK_NS         5
`define FCR_PC_WRITE_CYC   (`FCR_PC_WRITE_NS / `FCR_CLK_NS)

`endif

// File: fcr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.svh"
module fcr_host
(
	// Serial link driven by the host
	output logic      linkClk,
	output logic      chipSelN,
	output logic      serialIn,
	// Read data from the device
	input  wire logic serialOut,
	input  wire logic serialOutEnN
);
	logic [15:0] rxData;

	initial
	begin
		linkClk = 1'b0;
		chipSelN = 1'b1;
		serialIn = 1'b1;
		rxData = 16'h0000;
	end

	// The link clock stands low between frames, as a real controller parks it.
	task automatic frame(input logic [23:0] tx, input int nTx, input int nRx);
		int i;
		#4 chipSelN = 1'b0;
		for (i = 0; i < nTx; i++)
		begin
			serialIn = tx[23 - i];
			#15 linkClk = 1'b1;
			#15 linkClk = 1'b0;
		end
		serialIn = ~serialIn;
		for (i = 0; i < nRx; i++)
		begin
			#15 linkClk = 1'b1;
			rxData = {rxData[14:0], serialOutEnN ? ~rxData[0] : serialOut};
			#15 linkClk = 1'b0;
		end
		#15 chipSelN = 1'b1;
		serialIn = ~serialIn;
		#60;
	endtask : frame

	task automatic writeReg(input logic [23:0] tx, input int nTx, input logic en);
		if (en)
			frame({`FCR_CMD_WREN, 16'h0000}, 8, 0);
		frame(tx, nTx, 0);
	endtask : writeReg
endmodule : fcr_host
`default_nettype wire

// File: fcr_pkg.sv
package fcr_pkg;
	typedef enum logic [1:0] {FCR_WRAP16, FCR_WRAP32, FCR_WRAP64, FCR_CONT}
		fcr_wrap_t;
	typedef enum {FCR_CMD, FCR_HI, FCR_LO, FCR_END} fcr_state_t;
endpackage : fcr_pkg

// File: fcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fcr_sync
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Level in and out
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : fcr_sync
`default_nettype wire

// File: tb_fcr_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.svh"
module tb_fcr_config;
	logic               clk, rst;
	logic [23:0]        readAddr;
	wire                linkClk, chipSelN, serialIn, serialOut, serialOutEnN;
	wire [23:0]         nextAddr;
	wire [3:0]          dummyCycles;
	wire [2:0]          xipBootMode, driveStrength;
	wire                executeInPlace, doubleRate, dataLineThreePause;
	wire                quadProtocol, dualProtocol;
	wire                writeInProgress, writeEnableLatch;
	fcr_pkg::fcr_wrap_t wrapMode;
	wire [13:0]         cfg;
	int                 num_errors, comparisons, cycles;

	assign cfg = {dummyCycles, xipBootMode, driveStrength, doubleRate,
		dataLineThreePause, quadProtocol, dualProtocol};

	fcr_config fcr_config_inst (.clk, .rst, .linkClk, .chipSelN, .serialIn,
		.serialOut, .serialOutEnN, .readAddr, .nextAddr, .dummyCycles,
		.xipBootMode, .executeInPlace, .driveStrength, .doubleRate,
		.dataLineThreePause, .quadProtocol, .dualProtocol, .wrapMode,
		.writeInProgress, .writeEnableLatch);
	fcr_host fcr_host_inst (.linkClk, .chipSelN, .serialIn, .serialOut,
		.serialOutEnN);

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		readAddr = 24'h000000;
	end
	always #2.5 clk = ~clk;

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// A hung link frame would otherwise stall the run forever.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			summarize();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic pulseReset;
		@(posedge clk) rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulseReset

	task automatic t_defaults;
		check(cfg, {4'hf, 3'h7, 3'h7, 4'h4});
		check(executeInPlace, 1'b0);
		check(wrapMode, fcr_pkg::FCR_CONT);
		fcr_host_inst.frame({`FCR_CMD_RD_RC, 16'h0000}, 8, 8);
		check(fcr_host_inst.rxData[7:0], `FCR_RC_RESET);
		fcr_host_inst.frame({`FCR_CMD_RD_PC, 16'h0000}, 8, 16);
		check(fcr_host_inst.rxData, 16'hffff);
		fcr_host_inst.frame({`FCR_CMD_WREN, 16'h0000}, 8, 0);
		check(writeEnableLatch, 1'b1);
	endtask : t_defaults

	task automatic t_runtime;
		logic [7:0]  wr [4] = '{8'h00, 8'h2d, 8'he6, 8'h9f};
		logic [1:0]  w;
		logic [23:0] m;
		foreach (wr[i])
		begin
			fcr_host_inst.writeReg({`FCR_CMD_WR_RC, wr[i], 8'h00}, 16, 1'b1);
			w = wr[i][1:0];
			m = (w == 2'h3) ? 24'hffffff : (24'h000010 << w) - 24'h000001;
			check(dummyCycles, wr[i][7:4] == 4'h0 ? 4'hf : wr[i][7:4]);
			check(executeInPlace, !wr[i][3]);
			check(wrapMode, w);
			check(writeEnableLatch, 1'b0);
			@(posedge clk) readAddr <= 24'h12345f;
			@(negedge clk)
				check(nextAddr, (readAddr & ~m) |
					((readAddr + 24'h000001) & m));
			fcr_host_inst.frame({`FCR_CMD_RD_RC, 16'h0000}, 8, 8);
			check(fcr_host_inst.rxData[7:0], wr[i] & 8'hfb);
		end
		fcr_host_inst.writeReg({`FCR_CMD_WR_RC, 8'h00, 8'h00}, 16, 1'b0);
		check(wrapMode, fcr_pkg::FCR_CONT);
	endtask : t_runtime

	task automatic t_persist(input logic [15:0] v, input logic [13:0] c);
		int n;
		fcr_host_inst.writeReg({`FCR_CMD_WR_PC, v}, 24, 1'b1);
		check(writeInProgress, 1'b1);
		for (n = 0; n < 400 && writeInProgress !== 1'b0; n++)
			@(posedge clk);
		check(writeInProgress, 1'b0);
		pulseReset();
		check(cfg, c);
		check(executeInPlace, c[9:7] <= 3'h4);
		fcr_host_inst.frame({`FCR_CMD_RD_PC, 16'h0000}, 8, 16);
		check(fcr_host_inst.rxData, v | 16'h0003);
	endtask : t_persist

	initial
	begin
		pulseReset();
		t_defaults();
		t_runtime();
		t_persist(16'h8870, {4'h8, 3'h4, 3'h1, 4'h6});
		t_persist(16'h0fc8, {4'hf, 3'h7, 3'h7, 4'h9});
		summarize();
	end
endmodule : tb_fcr_config
`default_nettype wire
